/* File: logic/pcs_pkg.sv */
/*
  pcs_pkg: constants and types for the program counter sequencer.
  assumes one 40 MHz core clock and a synchronous active-low reset.
*/
`default_nettype none
package pcs_pkg;
  localparam int PCS_PC_W = 17;
  localparam int PCS_RAM_AW = 16;
  localparam int PCS_RAM_DW = 9;
  localparam logic [16:0] PCS_RESET_PC = 17'h00000;
  localparam logic PCS_RESET_BANK = 1'b0;
  localparam logic [16:0] PCS_VEC_BASE = 17'h00003;
  localparam logic [16:0] PCS_VEC_STEP = 17'h00008;
  localparam int PCS_VEC_COUNT = 10;
  localparam logic [16:0] PCS_VEC_LAST = 17'h0004b;
  localparam logic [15:0] PCS_ACC_ADDR = 16'hfe00;
  localparam logic [7:0] PCS_ACC_RESET = 8'h00;
  localparam logic [15:0] PCS_SFR_BASE = 16'hfe00;
  localparam logic [15:0] PCS_IREG_TOP = 16'h007f;
  localparam logic [16:0] PCS_OPTION_BASE = 17'h1ff00;
  localparam int PCS_STATUS_RAMBIT = 1;

  typedef enum logic [3:0] {
    PCS_OP_SEQ = 4'h0,
    PCS_OP_JUMP = 4'h1,
    PCS_OP_CALL = 4'h2,
    PCS_OP_RELBR = 4'h3,
    PCS_OP_RELCALL = 4'h4,
    PCS_OP_ACCCALL = 4'h5,
    PCS_OP_BCOND = 4'h6,
    PCS_OP_SUBRTN = 4'h7,
    PCS_OP_IRQRTN = 4'h8
  } pcs_op_t;

  typedef enum logic [5:0] {
    PCS_ST_IDLE = 6'b000001,
    PCS_ST_PUSH1 = 6'b000010,
    PCS_ST_PUSH2 = 6'b000100,
    PCS_ST_POP1 = 6'b001000,
    PCS_ST_POP2 = 6'b010000,
    PCS_ST_POPW = 6'b100000
  } pcs_state_t;

  typedef struct packed {
    pcs_op_t op;
    logic [2:0] len;
    logic [16:0] target;
    logic [11:0] off12;
    logic [7:0] off8;
    logic taken;
  } pcs_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [8:0] wdata;
    logic we;
    logic re;
  } pcs_ram_req_t;
endpackage
`default_nettype wire

/* File: logic/pcs_sequencer.sv */
/*
  pcs_sequencer: program counter, bank flag, stack save and restore,
  accumulator and status ninth-bit path, table look-up address forming.
  assumes stack RAM answers a read in the next cycle and that the
  decoder only issues an instruction while ready_o is high.
*/
`default_nettype none
// Function
// - counter is 17 bits plus a one-bit bank selector
// - low 17 bits address the selected bank linearly, no paging
// - ordinary instructions add their byte length, bank kept
// - reset loads address zero and clears the bank
// - interrupt loads vector 3 plus 8 per group, bank forced 0
// - absolute jump and call load 17-bit target, bank kept
// - relative branch adds 2 plus offset; acc call adds 1 plus acc
// - taken conditional branch adds length plus signed 8-bit offset
// - return: high 9 bits from top word, low byte and bank below
// - call saves bank and low byte at sp+1, high bits at sp+2
// - table look-up reaches any byte of the current bank
// - lower RAM is 9 bits wide, special area 8 or 9 bits
// - ninth RAM bit passes through status bit 1
// - first 128 RAM bytes pair into 64 indirect registers
// - table look-up treats indirect register as 17 bits
// - accumulator sits at special-area base, reset to zero
// - return decrements stack pointer after each restored word
module pcs_sequencer (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // instruction from decoder
  input wire logic instr_valid_i,
  input wire pcs_pkg::pcs_instr_t instr_i,
  output logic ready_o,
  // interrupt request
  input wire logic irq_valid_i,
  input wire logic [3:0] irq_group_i,
  output logic irq_ack_o,
  // stack pointer load from core
  input wire logic sp_load_i,
  input wire logic [15:0] sp_value_i,
  // table look-up address request
  input wire logic [5:0] lookup_reg_i,
  input wire logic lookup_req_i,
  output logic [17:0] lookup_addr_o,
  // stack RAM port
  output pcs_pkg::pcs_ram_req_t ram_o,
  input wire logic [8:0] ram_rdata_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [8:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [8:0] reg_rdata_o,
  // status ninth bit
  input wire logic ram_bit8_i,
  output logic status_rambit_o,
  // program counter
  output logic [16:0] pc_o,
  output logic bank_o,
  output logic [15:0] sp_o
);
  import pcs_pkg::*;

  pcs_state_t st_q, st_d;
  logic [16:0] pc_q, pc_d, sav_pc_q, sav_pc_d;
  logic bank_q, bank_d, sav_bank_q, sav_bank_d;
  logic [15:0] sp_q, sp_d;
  logic [8:0] hi_q, hi_d;
  pcs_ram_req_t ram_q, ram_d;
  logic ready_q, ready_d, ack_q, ack_d;
  logic [7:0] acc_q, acc_d;
  logic rambit_q, rambit_d;
  logic [8:0] rd_q, rd_d;
  logic [17:0] lk_q, lk_d;
  logic [7:0] ilo_q, ilo_d;
  logic [8:0] ihi_q, ihi_d;
  logic [16:0] vec [PCS_VEC_COUNT];

  genvar g;
  generate
    for (g = 0; g < PCS_VEC_COUNT; g++) begin : gen_vec
      assign vec[g] = PCS_VEC_BASE + 17'(g) * PCS_VEC_STEP;
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    bank_d = bank_q;
    sp_d = sp_q;
    hi_d = hi_q;
    sav_pc_d = sav_pc_q;
    sav_bank_d = sav_bank_q;
    ram_d = '0;
    ready_d = ready_q;
    ack_d = 1'b0;
    if (sp_load_i) begin
      sp_d = sp_value_i;
    end
    case (st_q)
      PCS_ST_IDLE: begin
        if (irq_valid_i && ready_q &&
            irq_group_i < 4'(PCS_VEC_COUNT)) begin
          sav_pc_d = pc_q;
          sav_bank_d = bank_q;
          pc_d = vec[irq_group_i];
          bank_d = 1'b0;
          ack_d = 1'b1;
          ready_d = 1'b0;
          st_d = PCS_ST_PUSH1;
        end else if (instr_valid_i && ready_q) begin
          case (instr_i.op)
            PCS_OP_JUMP: pc_d = instr_i.target;
            PCS_OP_CALL: begin
              sav_pc_d = pc_q + 17'(instr_i.len);
              sav_bank_d = bank_q;
              pc_d = instr_i.target;
              ready_d = 1'b0;
              st_d = PCS_ST_PUSH1;
            end
            PCS_OP_RELBR: pc_d = pc_q + 17'd2 +
                17'(signed'(instr_i.off12));
            PCS_OP_RELCALL: begin
              sav_pc_d = pc_q + 17'd2;
              sav_bank_d = bank_q;
              pc_d = pc_q + 17'd2 + 17'(signed'(instr_i.off12));
              ready_d = 1'b0;
              st_d = PCS_ST_PUSH1;
            end
            PCS_OP_ACCCALL: begin
              sav_pc_d = pc_q + 17'd1;
              sav_bank_d = bank_q;
              pc_d = pc_q + 17'd1 + {9'h000, acc_q};
              ready_d = 1'b0;
              st_d = PCS_ST_PUSH1;
            end
            PCS_OP_BCOND: begin
              pc_d = pc_q + 17'(instr_i.len);
              if (instr_i.taken) begin
                pc_d = pc_q + 17'(instr_i.len) +
                    17'(signed'(instr_i.off8));
              end
            end
            PCS_OP_SUBRTN, PCS_OP_IRQRTN: begin
              ram_d.addr = sp_q;
              ram_d.re = 1'b1;
              ready_d = 1'b0;
              st_d = PCS_ST_POP1;
            end
            default: pc_d = pc_q + 17'(instr_i.len);
          endcase
        end
      end
      PCS_ST_PUSH1: begin
        // bank and low byte at sp+1
        ram_d.addr = sp_q + 16'd1;
        ram_d.wdata = {sav_bank_q, sav_pc_q[7:0]};
        ram_d.we = 1'b1;
        st_d = PCS_ST_PUSH2;
      end
      PCS_ST_PUSH2: begin
        // high 9 bits at sp+2, then sp+2
        ram_d.addr = sp_q + 16'd2;
        ram_d.wdata = sav_pc_q[16:8];
        ram_d.we = 1'b1;
        sp_d = sp_q + 16'd2;
        ready_d = 1'b1;
        st_d = PCS_ST_IDLE;
      end
      PCS_ST_POP1: begin
        sp_d = sp_q - 16'd1;
        ram_d.addr = sp_q - 16'd1;
        ram_d.re = 1'b1;
        st_d = PCS_ST_POP2;
      end
      PCS_ST_POP2: begin
        hi_d = ram_rdata_i;
        st_d = PCS_ST_POPW;
      end
      PCS_ST_POPW: begin
        pc_d = {hi_q, ram_rdata_i[7:0]};
        bank_d = ram_rdata_i[8];
        sp_d = sp_q - 16'd1;
        ready_d = 1'b1;
        st_d = PCS_ST_IDLE;
      end
      default: begin
        st_d = PCS_ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // register port, accumulator and ninth bit
  always_comb begin
    acc_d = acc_q;
    rambit_d = ram_bit8_i;
    rd_d = 9'h000;
    if (reg_we_i && reg_addr_i == PCS_ACC_ADDR) begin
      acc_d = reg_wdata_i[7:0];
    end
    // lower region 9 bits, special area 8
    if (reg_we_i && reg_addr_i < PCS_SFR_BASE) begin
      rambit_d = reg_wdata_i[8];
    end
    if (reg_re_i) begin
      if (reg_addr_i == PCS_ACC_ADDR) begin
        rd_d = {1'b0, acc_q};
      end else if (reg_addr_i == 16'hfe0a) begin
        rd_d = {1'b0, sp_q[7:0]};
      end else if (reg_addr_i == 16'hfe0b) begin
        rd_d = {1'b0, sp_q[15:8]};
      end
    end
  end

  // indirect register pair as 17-bit look-up address
  always_comb begin
    ilo_d = ilo_q;
    ihi_d = ihi_q;
    lk_d = lk_q;
    if (reg_we_i && reg_addr_i <= PCS_IREG_TOP) begin
      if (reg_addr_i[6:1] == lookup_reg_i) begin
        if (reg_addr_i[0]) begin
          ihi_d = reg_wdata_i;
        end else begin
          ilo_d = reg_wdata_i[7:0];
        end
      end
    end
    if (lookup_req_i) begin
      lk_d = {bank_q, ihi_q, ilo_q};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_q <= PCS_ST_IDLE;
      pc_q <= PCS_RESET_PC;
      bank_q <= PCS_RESET_BANK;
      sp_q <= 16'h0000;
      hi_q <= 9'h000;
      sav_pc_q <= 17'h00000;
      sav_bank_q <= 1'b0;
      ram_q <= '0;
      ready_q <= 1'b1;
      ack_q <= 1'b0;
      acc_q <= PCS_ACC_RESET;
      rambit_q <= 1'b0;
      rd_q <= 9'h000;
      lk_q <= 18'h00000;
      ilo_q <= 8'h00;
      ihi_q <= 9'h000;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      bank_q <= bank_d;
      sp_q <= sp_d;
      hi_q <= hi_d;
      sav_pc_q <= sav_pc_d;
      sav_bank_q <= sav_bank_d;
      ram_q <= ram_d;
      ready_q <= ready_d;
      ack_q <= ack_d;
      acc_q <= acc_d;
      rambit_q <= rambit_d;
      rd_q <= rd_d;
      lk_q <= lk_d;
      ilo_q <= ilo_d;
      ihi_q <= ihi_d;
    end
  end

  assign pc_o = pc_q;
  assign bank_o = bank_q;
  assign sp_o = sp_q;
  assign ready_o = ready_q;
  assign irq_ack_o = ack_q;
  assign ram_o = ram_q;
  assign reg_rdata_o = rd_q;
  // ninth bit as status bit 1
  assign status_rambit_o = rambit_q;
  assign lookup_addr_o = lk_q;
endmodule
`default_nettype wire

/* File: tb/pcs_sequencer_props.sv */
/*
  pcs_sequencer_props: port relations of the sequencer.
  assumes bind into pcs_sequencer and a single clock.
*/
`default_nettype none
module pcs_sequencer_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic instr_valid_i,
  input wire pcs_pkg::pcs_instr_t instr_i,
  input wire logic ready_o,
  input wire logic irq_valid_i,
  input wire logic [3:0] irq_group_i,
  input wire logic irq_ack_o,
  input wire pcs_pkg::pcs_ram_req_t ram_o,
  input wire logic [15:0] reg_addr_i,
  input wire logic [8:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic status_rambit_o,
  input wire logic [16:0] pc_o,
  input wire logic bank_o,
  input wire logic [15:0] sp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic take;
  assign take = instr_valid_i && ready_o && !irq_valid_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n_i |=> pc_o == 17'h0 && !bank_o && sp_o == 16'h0)
    else $error("state not cleared");
  irq_vector_a: assert property (
    irq_ack_o |-> !bank_o &&
    pc_o == PCS_VEC_BASE + {$past(irq_group_i), 3'h0})
    else $error("bad vector");
  seq_step_a: assert property (
    take && instr_i.op == PCS_OP_SEQ
    |=> pc_o == $past(pc_o + instr_i.len) && $stable(bank_o))
    else $error("bad step");
  bcond_step_a: assert property (
    take && instr_i.op == PCS_OP_BCOND && instr_i.taken |=> pc_o ==
    $past(pc_o + instr_i.len + {{9{instr_i.off8[7]}}, instr_i.off8}))
    else $error("bad branch");
  jump_load_a: assert property (
    take && instr_i.op inside {PCS_OP_JUMP, PCS_OP_CALL}
    |=> pc_o == $past(instr_i.target) && $stable(bank_o))
    else $error("bad target");
  call_push_a: assert property (
    take && instr_i.op inside {PCS_OP_CALL, PCS_OP_RELCALL, PCS_OP_ACCCALL}
    |=> !ready_o ##1 ram_o.we && ram_o.addr == $past(sp_o, 2) + 16'h1
    ##1 ram_o.we && ram_o.addr == $past(sp_o, 3) + 16'h2)
    else $error("bad push");
  ret_pop_a: assert property (
    take && instr_i.op inside {PCS_OP_SUBRTN, PCS_OP_IRQRTN}
    |=> !ready_o [*3] ##1 ready_o && sp_o == $past(sp_o, 4) - 16'h2)
    else $error("bad pop");
  ninth_bit_a: assert property (
    reg_we_i && reg_addr_i < PCS_SFR_BASE
    |=> status_rambit_o == $past(reg_wdata_i[8]))
    else $error("bad ninth bit");
endmodule
`default_nettype wire

/* File: tb/pcs_stack_ram.sv */
/*
  pcs_stack_ram: 9-bit stack RAM behind the sequencer.
  assumes a read answers in the next cycle only.
*/
`default_nettype none
module pcs_stack_ram (
  // clock
  input wire logic clock_i,
  // ram port
  input wire pcs_pkg::pcs_ram_req_t ram_i,
  output logic [8:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic [8:0] mem [256];
  logic [8:0] last_q = 9'h0;
  logic hit_q = 1'b0;
  always @(posedge clock_i) begin
    if (ram_i.we) mem[ram_i.addr[7:0]] <= ram_i.wdata;
    if (ram_i.re) last_q <= mem[ram_i.addr[7:0]];
    hit_q <= ram_i.re;
  end
  // stale data inverted outside the answer cycle
  assign rdata_o = hit_q ? last_q : ~last_q;
endmodule
`default_nettype wire

/* File: tb/tb_pcs_sequencer.sv */
/*
  tb_pcs_sequencer: directed tests of the program counter sequencer.
  assumes the stack RAM model and the bound checker.
*/
`default_nettype none
module tb_pcs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic clock_i = 0, rst_n_i = 0, iv = 0, qv = 0, lq = 0, we = 0, re = 0;
  logic r8 = 1'b0;
  logic [3:0] qg = 4'h0;
  logic [5:0] lr = 6'h0;
  logic [15:0] ra = 16'h0, sp, s;
  logic [8:0] rw = 9'h0, rdq, rr;
  pcs_instr_t ins = '0;
  pcs_ram_req_t rq;
  logic rdy, ack, bk, rb, be;
  logic [17:0] la;
  logic [16:0] pc, pe;
  int num_errors = 0, checks = 0;
  always #12.5 clock_i = ~clock_i;
  pcs_sequencer dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .instr_valid_i(iv), .instr_i(ins), .ready_o(rdy), .irq_valid_i(qv),
    .irq_group_i(qg), .irq_ack_o(ack), .sp_load_i(1'b0),
    .sp_value_i(16'h0), .lookup_reg_i(lr), .lookup_req_i(lq),
    .lookup_addr_o(la), .ram_o(rq), .ram_rdata_i(rr), .reg_addr_i(ra),
    .reg_wdata_i(rw), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdq),
    .ram_bit8_i(r8), .status_rambit_o(rb), .pc_o(pc), .bank_o(bk),
    .sp_o(sp));
  pcs_stack_ram ram (.clock_i(clock_i), .ram_i(rq), .rdata_o(rr));
  task automatic chk(string n, logic [31:0] v, e);
    checks++;
    if (v !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(logic [15:0] a, logic [8:0] d);
    @(posedge clock_i);
    ra <= a;
    rw <= d;
    we <= 1'b1;
    @(posedge clock_i);
    we <= 1'b0;
  endtask
  task automatic rd(string n, logic [15:0] a, logic [8:0] e);
    @(posedge clock_i);
    ra <= a;
    re <= 1'b1;
    @(posedge clock_i);
    re <= 1'b0;
    #1 chk(n, rdq, e);
  endtask
  task automatic go(pcs_op_t op, logic [2:0] l, logic [16:0] t,
    logic [11:0] o, logic [7:0] b);
    @(posedge clock_i);
    ins <= '{op, l, t, o, b, 1'b1};
    iv <= 1'b1;
    @(posedge clock_i);
    iv <= 1'b0;
    repeat (8) begin
      #1;
      if (rdy === 1'b1) break;
      @(posedge clock_i);
    end
  endtask
  task automatic rt(pcs_op_t op, logic [15:0] t, logic [8:0] h, lo);
    #1 ram.mem[t[7:0]] = h;
    ram.mem[t[7:0] - 8'h1] = lo;
    go(op, 3'h1, 17'h0, 12'h0, 8'h0);
    chk("rpc", pc, {h, lo[7:0]});
    chk("rbk", bk, lo[8]);
    chk("rsp", sp, t - 16'h2);
  endtask
  task automatic irq(logic [3:0] g, logic a, logic [16:0] v);
    @(posedge clock_i);
    qv <= 1'b1;
    qg <= g;
    iv <= g == 4'h9;
    @(posedge clock_i);
    qv <= 1'b0;
    iv <= 1'b0;
    #1 chk("ack", ack, a);
    chk("vec", pc, v);
    chk("vbk", bk, 1'b0);
    repeat (4) @(posedge clock_i);
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1 chk("pc0", pc, 17'h0);
    chk("bk0", bk, 1'b0);
    rd("acc0", PCS_ACC_ADDR, 9'h000);
    go(PCS_OP_SEQ, 3'h3, 17'h0, 12'h0, 8'h0);
    chk("seq", pc, 17'h00003);
    go(PCS_OP_JUMP, 3'h3, 17'h1fef0, 12'h0, 8'h0);
    chk("jmp", pc, 17'h1fef0);
    go(PCS_OP_RELBR, 3'h2, 17'h0, 12'h800, 8'h0);
    chk("br", pc, 17'h1f6f2);
    go(PCS_OP_BCOND, 3'h3, 17'h0, 12'h0, 8'h80);
    chk("bc", pc, 17'h1f675);
    go(PCS_OP_CALL, 3'h3, 17'h00100, 12'h0, 8'h0);
    chk("call", pc, 17'h00100);
    wr(PCS_ACC_ADDR, 9'h0ff);
    rd("acc", PCS_ACC_ADDR, 9'h0ff);
    go(PCS_OP_ACCCALL, 3'h1, 17'h0, 12'h0, 8'h0);
    chk("rca", pc, 17'h00200);
    rd("spl", 16'hfe0a, 9'h004);
    rd("none", 16'hfe30, 9'h000);
    rt(PCS_OP_IRQRTN, 16'h4, 9'h0aa, 9'h012);
    rt(PCS_OP_SUBRTN, 16'h2, 9'h155, 9'h1cd);
    go(PCS_OP_RELCALL, 3'h2, 17'h0, 12'h7ff, 8'h0);
    chk("rc", pc, 17'h15dce);
    chk("rcbk", bk, 1'b1);
    @(posedge clock_i);
    lr <= 6'h3f;
    wr(16'h007e, 9'h034);
    wr(16'h007f, 9'h1a5);
    #1 chk("bit8", rb, 1'b1);
    @(posedge clock_i);
    r8 <= 1'b1;
    @(posedge clock_i);
    r8 <= 1'b0;
    #1 chk("bit8r", rb, 1'b1);
    @(posedge clock_i);
    lq <= 1'b1;
    @(posedge clock_i);
    lq <= 1'b0;
    #1 chk("lut", la, 18'h3a534);
    pe = 17'h15dce;
    be = 1'b1;
    s = 16'h2;
    for (int g = 0; g < 11; g++) begin
      irq(g[3:0], g < 10, g < 10 ? 17'(3 + 8 * g) : pe);
      if (g < 10) begin
        #1 chk("lo", ram.mem[s[7:0] + 8'h1], {be, pe[7:0]});
        chk("hi", ram.mem[s[7:0] + 8'h2], pe[16:8]);
        s = s + 16'h2;
        chk("sp", sp, s);
        pe = 17'(3 + 8 * g);
        be = 1'b0;
      end
    end
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1 chk("rst", pc, 17'h0);
    rd("racc", PCS_ACC_ADDR, 9'h000);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    final_report();
  end
endmodule
bind pcs_sequencer pcs_sequencer_props props (.clock_i, .rst_n_i,
  .instr_valid_i, .instr_i, .ready_o, .irq_valid_i, .irq_group_i,
  .irq_ack_o, .ram_o, .reg_addr_i, .reg_wdata_i, .reg_we_i,
  .status_rambit_o, .pc_o, .bank_o, .sp_o);
`default_nettype wire
